// ---- include/rcr_link_if.sv ----
// control word out to the decoder and carrier, their results back to the top
// assumes all three parties run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface rcr_link_if;
	import rcr_pkg::*;
	logic [CTRL_W-1:0] ctrl; // live control register
	rcr_decoded_type dec; // registered field decode
	logic run; // carrier running
	logic msb; // carrier dac msb
	modport top (output ctrl, input dec, input run, input msb);
	modport decode (input ctrl, output dec);
	modport carrier (input ctrl, output run, output msb);
endinterface
`default_nettype wire

// ---- include/rcr_pkg.sv ----
// constants, field layout and decoded-control type for the respiration control block
// assumes a 40 MHz system clock and one AHB-Lite word per register
package rcr_pkg;
	localparam int unsigned CLK_HZ = 40_000_000; // system clock rate
	// printed register index; byte address is four times it
	localparam logic [7:0] IDX_CTRL = 8'h03;
	localparam logic [7:0] ADDR_CTRL = 8'(4 * IDX_CTRL);
	localparam logic [7:0] ADDR_SRST = 8'h10; // soft reset strobe register
	localparam logic [7:0] ADDR_STAT = 8'h14; // carrier status register
	localparam int CTRL_W = 24; // control register width
	localparam logic [23:0] CTRL_RST = 24'h000000; // every field defaults clear
	localparam logic [23:0] CTRL_MASK = 24'h01FFFF; // bits 23..17 reserved
	// field positions
	localparam int B_EN = 0;
	localparam int B_FREQ = 1;
	localparam int B_AMP = 3;
	localparam int B_SEL = 5;
	localparam int B_EXTSEL = 7;
	localparam int B_GAIN = 8;
	localparam int B_CAP = 12;
	localparam int B_OUT = 13;
	localparam int B_BYP = 14;
	localparam int B_SYNC = 15;
	localparam int B_PER = 16;
	localparam int B_SRST = 0;
	// field codes
	localparam logic [3:0] GAIN_MAX_CODE = 4'h9;
	localparam logic [3:0] GAIN_MAX = 4'hA;
	localparam logic [1:0] LEAD_II = 2'h1;
	localparam logic [1:0] LEAD_III = 2'h2;
	localparam logic [1:0] LEAD_EXT = 2'h3;
	// ahb encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// carrier rates in Hz, indexed by the frequency code
	localparam int unsigned APER_HZ [4] = '{56000, 54000, 52000, 50000};
	localparam int unsigned PER_HZ [4] = '{64000, 56900, 51200, 46500};
	localparam int PHASE_W = 24; // accumulator width of the aperiodic carrier
	// clocks per carrier cycle, rounded down
	function automatic logic [15:0] period_cycles(input logic [1:0] code);
		period_cycles = 16'(CLK_HZ / PER_HZ[code]);
	endfunction
	// accumulator step per clock for the aperiodic carrier
	function automatic logic [PHASE_W-1:0] phase_inc(input logic [1:0] code);
		phase_inc = PHASE_W'((longint'(APER_HZ[code]) << PHASE_W) / longint'(CLK_HZ));
	endfunction
	typedef struct packed {
		logic [3:0] gain;
		logic bypass;
		logic cap_ext;
		logic drv_ll;
		logic drv_la;
		logic drv_ra;
		logic sns_ll;
		logic sns_la;
		logic sns_ra;
		logic lead_ii;
		logic lead_iii;
		logic [1:0] tone_shift;
		logic sync_en;
	} rcr_decoded_type;
endpackage

// ---- rtl/rcr_carrier_gen.sv ----
// carrier generator: square dac msb at the selected rate while enabled
// assumes the control word is synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module rcr_carrier_gen (
	input wire logic clock,
	input wire logic rst_n,
	rcr_link_if.carrier link
);
	import rcr_pkg::*;
	typedef struct packed {
		logic [15:0] cnt; // periodic-mode cycle counter
		logic [PHASE_W-1:0] acc; // aperiodic phase accumulator
		logic msb; // dac msb
		logic run; // carrier active
	} rcr_car_type;
	rcr_car_type s;
	rcr_car_type next_s;
	logic [15:0] per; // clocks per periodic cycle
	logic [1:0] code; // frequency code

	// periodic mode: integer divider, constant period; aperiodic: fractional
	// accumulator, mean rate just under the target as the step is rounded down, period jitters by one clock
	always_comb begin
		code = link.ctrl[B_FREQ +: 2];
		per = period_cycles(code);
		next_s = s;
		if (!link.ctrl[B_EN]) begin
			next_s = '0;
		end else if (link.ctrl[B_PER]) begin
			next_s.run = 1'b1;
			next_s.acc = '0;
			next_s.cnt = (s.cnt >= per - 16'h1) ? 16'h0 : s.cnt + 16'h1;
			next_s.msb = next_s.cnt >= (per >> 1);
		end else begin
			next_s.run = 1'b1;
			next_s.cnt = '0;
			next_s.acc = s.acc + phase_inc(code);
			next_s.msb = next_s.acc[PHASE_W-1];
		end
	end

	// carrier state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign link.run = s.run;
	assign link.msb = s.msb;

	// helper: clocks since last msb rise under an unchanged control word
	logic [15:0] since;
	logic steady;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			since <= '0;
			steady <= 1'b0;
		end else begin
			since <= (!s.msb && next_s.msb) ? 16'h0 : since + 16'h1;
			steady <= (steady | (!s.msb && next_s.msb)) && $stable(link.ctrl);
		end
	end
	default clocking ccb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_idle_quiet: assert property (!link.ctrl[B_EN] |=> !s.msb && !s.run) else $error("carrier runs while disabled");
	// checked at the edge that raises msb again, one full period after the last rise
	a_period_fixed: assert property (steady && link.ctrl[B_PER] && !s.msb && next_s.msb |-> since == period_cycles(link.ctrl[B_FREQ +: 2]) - 16'h1) else $error("periodic carrier period wrong");
	c_periodic: cover property (link.ctrl[B_PER] && $rose(s.msb));
endmodule
`default_nettype wire

// ---- rtl/rcr_field_decode.sv ----
// field decoder: turns the control word into registered analog steering lines
// assumes the control word and reset come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module rcr_field_decode (
	input wire logic clock,
	input wire logic rst_n,
	rcr_link_if.decode link
);
	import rcr_pkg::*;
	rcr_decoded_type s; // registered decode
	rcr_decoded_type next_s; // next decode
	logic [CTRL_W-1:0] c; // short alias of the word
	logic en; // measurement enabled
	logic ext; // external lead path chosen
	assign c = link.ctrl;

	// field decode; drives and senses idle while disabled
	always_comb begin
		en = c[B_EN];
		ext = c[B_SEL +: 2] == LEAD_EXT;
		next_s = '0;
		next_s.gain = (c[B_GAIN +: 4] > GAIN_MAX_CODE) ? GAIN_MAX : c[B_GAIN +: 4] + 4'h1;
		next_s.bypass = c[B_BYP];
		next_s.cap_ext = c[B_CAP];
		next_s.drv_ll = en & ~c[B_OUT];
		next_s.drv_la = en & c[B_OUT];
		// right arm belongs to both pairs and to external caps
		next_s.drv_ra = en;
		next_s.sns_ll = en & ext & ~c[B_EXTSEL];
		next_s.sns_la = en & ext & c[B_EXTSEL];
		next_s.sns_ra = en & ext;
		next_s.lead_ii = en & (c[B_SEL +: 2] == LEAD_II);
		next_s.lead_iii = en & (c[B_SEL +: 2] == LEAD_III);
		// divide by 8,4,2,1 as a right shift of 3..0
		next_s.tone_shift = ~c[B_AMP +: 2];
		next_s.sync_en = en & c[B_SYNC];
	end

	// decode register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign link.dec = s;

	default clocking dcb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_gain_saturates: assert property (link.ctrl[B_GAIN +: 4] > GAIN_MAX_CODE |=> s.gain == GAIN_MAX) else $error("gain not saturated");
	a_gain_plus_one: assert property (link.ctrl[B_GAIN +: 4] <= GAIN_MAX_CODE |=> s.gain == $past(link.ctrl[B_GAIN +: 4]) + 4'h1) else $error("gain not code plus one");
	a_drive_pair: assert property (link.ctrl[B_EN] |=> s.drv_ra && (s.drv_la != s.drv_ll) && s.drv_la == $past(link.ctrl[B_OUT])) else $error("drive pair wrong");
	a_sense_gated: assert property (link.ctrl[B_SEL +: 2] != LEAD_EXT |=> !s.sns_ll && !s.sns_la && !s.sns_ra) else $error("sense path without external lead");
	c_gain_max: cover property (s.gain == GAIN_MAX);
endmodule
`default_nettype wire

// ---- rtl/rcr_respiration_control.sv ----
// respiration control register: AHB-Lite slave, field steering and carrier sync pin
// assumes one AHB-Lite master on clock, single word transfers
`timescale 1ns/1ps
`default_nettype none
module rcr_respiration_control #(
	parameter int ADDR_W = 8 // decoded low address bits
) (
	input wire logic clock,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// normal function of the general pin
	input wire logic gpio_func_out,
	input wire logic gpio_func_oe,
	output logic general_pin_three_out,
	output logic general_pin_three_oe,
	// analog steering
	output logic [3:0] inamp_gain,
	output logic external_amplifier_bypass,
	output logic capacitor_external,
	output logic drive_out_left_leg,
	output logic drive_out_left_arm,
	output logic drive_out_right_arm,
	output logic ext_sense_left_leg,
	output logic ext_sense_left_arm,
	output logic ext_sense_right_arm,
	output logic lead_ii_select,
	output logic lead_iii_select,
	output logic [1:0] test_tone_shift,
	output logic carrier_dac_msb,
	output logic measurement_enable
);
	import rcr_pkg::*;

	// the status word and addresses need at least five address bits
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
		$error("ADDR_W must be 5..32");
	end

	// decoded addresses at the parameter width
	localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(ADDR_CTRL);
	localparam logic [ADDR_W-1:0] A_SRST = ADDR_W'(ADDR_SRST);
	localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(ADDR_STAT);

	// bus, register and pin state in one word; the reset synchroniser stands apart
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl; // respiration_control
		logic dp_wr; // write data phase pending
		logic [ADDR_W-1:0] dp_addr; // its address
		logic [31:0] rdata; // read data for the data phase
		logic ready; // hreadyout
		logic pin_out; // general pin level
		logic pin_oe; // general pin enable
	} rcr_top_type;

	rcr_top_type s; // registered state
	rcr_top_type next_s; // next state
	logic [1:0] rst_sync; // release synchroniser
	logic rst_int_n; // synchronised reset
	logic take; // address phase accepted
	rcr_link_if link (); // control bundle to the leaves

	// asynchronous assert, release after two clocks so no flop sees
	// a reset edge near a clock edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync[1];

	// bus, register and pin next state
	always_comb begin
		next_s = s;
		// zero wait states, never an error
		next_s.ready = 1'b1;
		// data phase: land the write from the previous address phase
		if (s.dp_wr) begin
			if (s.dp_addr == A_CTRL) begin
				// reserved bits are dropped, so they read as zero
				next_s.ctrl = hwdata[CTRL_W-1:0] & CTRL_MASK;
			end else if (s.dp_addr == A_SRST && hwdata[B_SRST]) begin
				// soft reset: all fields back to their defaults
				next_s.ctrl = CTRL_RST;
			end
		end
		// address phase: only nonseq/seq counts, and a write only as a whole word
		take = hsel && hready && htrans[1];
		next_s.dp_wr = take && hwrite && (hsize == HSIZE_WORD);
		next_s.dp_addr = haddr[ADDR_W-1:0];
		next_s.rdata = '0;
		// control reads see a write landing this same edge
		if (take && !hwrite) begin
			case (haddr[ADDR_W-1:0])
				A_CTRL: begin
					next_s.rdata = {{(32 - CTRL_W){1'b0}}, next_s.ctrl};
				end
				A_STAT: begin
					next_s.rdata = {29'h0, link.run & s.ctrl[B_PER], link.msb, link.run};
				end
				default: begin
					// unmapped and the write-only strobe read zero
					next_s.rdata = '0;
				end
			endcase
		end
		// general pin: carrier msb while sync is on, normal function otherwise
		if (link.dec.sync_en) begin
			next_s.pin_out = link.msb;
			next_s.pin_oe = 1'b1;
		end else begin
			next_s.pin_out = gpio_func_out;
			next_s.pin_oe = gpio_func_oe;
		end
	end

	// state register; power-down is not a reset, so contents persist
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			s.ctrl <= CTRL_RST;
			s.dp_wr <= 1'b0;
			s.dp_addr <= '0;
			s.rdata <= '0;
			s.ready <= 1'b1;
			s.pin_out <= 1'b0;
			s.pin_oe <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign link.ctrl = s.ctrl;

	// field decoder
	rcr_field_decode u_decode (
		.clock(clock),
		.rst_n(rst_int_n),
		.link(link.decode)
	);

	// carrier generator
	rcr_carrier_gen u_carrier (
		.clock(clock),
		.rst_n(rst_int_n),
		.link(link.carrier)
	);

	// bus outputs straight from flops, hresp tied low
	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = 1'b0;
	assign general_pin_three_out = s.pin_out;
	assign general_pin_three_oe = s.pin_oe;
	// analog steering from the decoder flops
	assign inamp_gain = link.dec.gain;
	assign external_amplifier_bypass = link.dec.bypass;
	assign capacitor_external = link.dec.cap_ext;
	assign drive_out_left_leg = link.dec.drv_ll;
	assign drive_out_left_arm = link.dec.drv_la;
	assign drive_out_right_arm = link.dec.drv_ra;
	assign ext_sense_left_leg = link.dec.sns_ll;
	assign ext_sense_left_arm = link.dec.sns_la;
	assign ext_sense_right_arm = link.dec.sns_ra;
	assign lead_ii_select = link.dec.lead_ii;
	assign lead_iii_select = link.dec.lead_iii;
	assign test_tone_shift = link.dec.tone_shift;
	// carrier msb comes from the generator flop
	assign carrier_dac_msb = link.msb;
	assign measurement_enable = s.ctrl[B_EN];

	// checks on the bus, register and pin
	default clocking tcb @(posedge clock); endclocking
	default disable iff (!rst_int_n);

	a_ready_okay: assert property (hreadyout && !hresp) else $error("slave stalled or errored");
	a_ctrl_write: assert property (s.dp_wr && s.dp_addr == A_CTRL |=> s.ctrl == ($past(hwdata[CTRL_W-1:0]) & CTRL_MASK)) else $error("control write lost");
	a_reserved_zero: assert property (s.ctrl[CTRL_W-1:B_PER+1] == '0) else $error("reserved bits set");
	a_soft_reset: assert property (s.dp_wr && s.dp_addr == A_SRST && hwdata[B_SRST] |=> s.ctrl == CTRL_RST) else $error("soft reset ignored");
	a_ctrl_read: assert property (hsel && hready && htrans[1] && !hwrite && haddr[ADDR_W-1:0] == A_CTRL && !s.dp_wr |=> hrdata == {8'h00, $past(s.ctrl)}) else $error("control readback wrong");
	a_sync_pin: assert property (link.dec.sync_en |=> general_pin_three_oe && general_pin_three_out == $past(link.msb)) else $error("sync pin not carrier msb");
	a_pin_normal: assert property (!link.dec.sync_en |=> general_pin_three_out == $past(gpio_func_out) && general_pin_three_oe == $past(gpio_func_oe)) else $error("pin lost normal function");
	a_enable_starts: assert property (!s.ctrl[B_EN] ##1 s.ctrl[B_EN] |=> ##1 link.run) else $error("carrier did not start");

	c_write_ctrl: cover property (s.dp_wr && s.dp_addr == A_CTRL);
	c_soft_reset: cover property (s.dp_wr && s.dp_addr == A_SRST && hwdata[B_SRST]);
	c_sync_out: cover property (link.dec.sync_en && $rose(general_pin_three_out));
endmodule
`default_nettype wire

// ---- tb/rcr_host_model.sv ----
// host-side AHB-Lite master model: single word transfers, one at a time
// assumes one slave whose hreadyout is wired back as hready
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
	input wire logic clock,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output var logic hsel,
	output var logic [31:0] haddr,
	output var logic [1:0] htrans,
	output var logic hwrite,
	output var logic [2:0] hsize,
	output var logic [31:0] hwdata,
	output var logic [31:0] rd_data,
	output var int rd_count
);
	// bus idle at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		rd_data = 32'h00000000;
		rd_count = 0;
	end
	// one transfer; waits as long as the slave stalls, bench timeout cuts a hang
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge clock);
		while (!hready) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= data & 32'h0001FFFF;
		@(posedge clock);
		while (!hready) @(posedge clock);
		// read data taken at the closing edge, count bump tells the monitor
		if (!wr) begin
			rd_data <= hrdata;
			rd_count <= rd_count + 1;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/rcr_respiration_control_tb.sv ----
// self-checking bench for the respiration control register block
// assumes the host model drives the bus; reads are checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
module rcr_respiration_control_tb;
	import rcr_pkg::*;
	logic clock, rst_n, gf_out, gf_oe, hreadyout, hresp;
	logic hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, rd_data;
	logic [1:0] htrans, tts;
	logic [2:0] hsize;
	logic [3:0] gain;
	logic byp, cap, dll, dla, dra, sll, sla, sra, l2, l3, msb, men, pin, pin_oe;
	int rd_count, seen, n_mismatch, total_checks, cyc, seed;
	logic [31:0] expq[$]; // expected read words, oldest first
	int unsigned per_hz[4] = '{64000, 56900, 51200, 46500};
	int unsigned aper_hz[4] = '{56000, 54000, 52000, 50000};
	rcr_host_model host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.rd_data(rd_data), .rd_count(rd_count));
	rcr_respiration_control DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_func_out(gf_out),
		.gpio_func_oe(gf_oe), .general_pin_three_out(pin), .general_pin_three_oe(pin_oe),
		.inamp_gain(gain), .external_amplifier_bypass(byp), .capacitor_external(cap),
		.drive_out_left_leg(dll), .drive_out_left_arm(dla), .drive_out_right_arm(dra),
		.ext_sense_left_leg(sll), .ext_sense_left_arm(sla), .ext_sense_right_arm(sra),
		.lead_ii_select(l2), .lead_iii_select(l3), .test_tone_shift(tts),
		.carrier_dac_msb(msb), .measurement_enable(men));
	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// verdict and end of run, shared by main flow and timeout
	task automatic complete_run;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	// note the expected word, then issue the read
	task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
		expq.push_back(exp);
		host.xfer(1'b0, addr, 32'h0);
	endtask
	// steering outputs worked out from a control word
	function automatic logic [16:0] exp_out(input logic [23:0] d);
		logic e, x;
		logic [3:0] g;
		e = d[0];
		x = e & (d[6:5] == 2'h3);
		g = (d[11:8] > 4'h9) ? 4'hA : d[11:8] + 4'h1;
		return {g, d[14], d[12], e & ~d[13], e & d[13], e, x & ~d[7], x & d[7], x,
			e & (d[6:5] == 2'h1), e & (d[6:5] == 2'h2), ~d[4:3], e};
	endfunction
	// span of n carrier periods; also tallies pin samples not one edge behind msb
	task automatic span(input int n, output int c, output int pe);
		logic p;
		int k;
		c = 0;
		pe = 0;
		k = -1;
		p = msb;
		while (k < n) begin
			@(negedge clock);
			if (k >= 0) c++;
			if (pin !== p || pin_oe !== 1'b1) pe++;
			if (msb && !p) k++;
			p = msb;
		end
	endtask
	// read monitor: each completed read takes the oldest note
	always @(negedge clock) begin
		if (rd_count != seen) begin
			seen = rd_count;
			check(rd_data, expq.pop_front());
		end
	end
	// normal pin function wanders randomly
	always @(posedge clock) begin
		gf_out <= 1'($random(seed));
		gf_oe <= 1'($random(seed));
		cyc++;
		if (cyc == 80000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		logic [23:0] d;
		logic po, pq;
		int c, pe;
		seed = 37;
		rst_n = 1'b0;
		gf_out = 1'b0;
		gf_oe = 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(32'(ADDR_CTRL), 32'h0);
		check(32'({gain, byp, cap, dll, dla, dra, sll, sla, sra, l2, l3, tts, men}),
			32'(exp_out(24'h0)));
		check(32'({msb, hresp}), 32'h0);
		// field sweep: every gain and lead code, random remainder
		for (int i = 0; i < 32; i++) begin
			d = 24'($random(seed)) & 24'h01FFFF;
			if (i < 16) d[11:8] = 4'(i);
			d[6:5] = 2'(i);
			host.xfer(1'b1, 32'(ADDR_CTRL), 32'(d));
			rd(32'(ADDR_CTRL), 32'(d));
			@(negedge clock);
			check(32'({gain, byp, cap, dll, dla, dra, sll, sla, sra, l2, l3, tts, men}),
				32'(exp_out(d)));
		end
		// periodic carrier on the sync pin: exact, constant period
		for (int f = 0; f < 4; f++) begin
			host.xfer(1'b1, 32'(ADDR_CTRL), 32'h018001 | 32'(f << 1));
			span(1, c, pe);
			span(2, c, pe);
			check(32'(c), 32'(2 * (40000000 / per_hz[f])));
			check(32'(pe), 32'h0);
		end
		// aperiodic carrier: average rate over eight periods, one clock jitter each
		for (int f = 0; f < 4; f++) begin
			host.xfer(1'b1, 32'(ADDR_CTRL), 32'h008001 | 32'(f << 1));
			span(1, c, pe);
			span(8, c, pe);
			c = c - 8 * 40000000 / aper_hz[f];
			check(32'(c >= -3 && c <= 3), 32'h1);
		end
		// disabled: no carrier, pin back to its normal function
		host.xfer(1'b1, 32'(ADDR_CTRL), 32'h018000);
		repeat (3) @(negedge clock);
		pe = 0;
		for (int i = 0; i < 20; i++) begin
			po = gf_out;
			pq = gf_oe;
			@(negedge clock);
			if (pin !== po || pin_oe !== pq || msb !== 1'b0) pe++;
		end
		check(32'(pe), 32'h0);
		// soft reset restores defaults; unmapped read gives zero
		host.xfer(1'b1, 32'(ADDR_CTRL), 32'h01FFFF);
		host.xfer(1'b1, 32'(ADDR_SRST), 32'h1);
		rd(32'(ADDR_CTRL), 32'h0);
		rd(32'h20, 32'h0);
		rd(32'(ADDR_STAT), 32'h0);
		repeat (3) @(posedge clock);
		check(32'(expq.size()), 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
